// *** rtl/edge_if.sv ***
// Interface between the pin conditioning unit and the timer core.
`timescale 1ns/100ps
`default_nettype none
interface edge_if;
    logic rise_pulse; // One-cycle pulse on a counted rising edge.
    logic gate_low; // Filtered gate pin is low.
    logic arm_clear; // Forget any seen falling edge.
    modport unit (output rise_pulse, output gate_low, input arm_clear);
    modport core (input rise_pulse, input gate_low, output arm_clear);
endinterface
`default_nettype wire

// *** rtl/gated_sixteen_bit_timer.sv ***
// Gated sixteen bit timer/counter with an Avalon-MM register slave.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module gated_sixteen_bit_timer
    import gated_timer_pkg::*;
(
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic external_count_clock_in,
    input wire logic crystal_output_pin_in,
    input wire logic gate_input_n_in,
    input wire logic internal_oscillator_in,
    input wire logic sleep_in,
    output logic irq_out,
    output logic wake_out,
    output logic lowpower_osc_run_out
);

    // ****************************************
    // State and next values.
    // ****************************************
    bus_state_t bus_reg, bus_next; // Bus answer phase.
    logic [31:0] rdata_reg, rdata_next; // Captured read data.
    logic [7:0] ctrl_reg, ctrl_next; // Control register.
    logic [3:0] irqc_reg, irqc_next; // Flag and enables.
    logic [15:0] count_reg, count_next; // The count itself.
    logic [2:0] presc_reg, presc_next; // Hidden prescaler.
    logic [1:0] div_reg, div_next; // Instruction cycle divider.
    logic irq_reg, irq_next; // Interrupt output.
    logic wake_reg, wake_next; // Wake output.
    logic osc_reg, osc_next; // Crystal run output.

    // ****************************************
    // Decoded control fields.
    // ****************************************
    logic counter_on, clock_source_select, sync_bypass;
    logic lowpower_osc_enable, gate_enable;
    logic [1:0] prescale_select;
    logic rollover_flag;
    logic accept; // Request is answered this cycle.
    logic wr_low, wr_high, wr_ctrl, wr_irq; // Accepted writes.
    logic count_write; // Either count byte written.
    logic quarter_tick; // One pulse per instruction cycle.
    logic src_pulse; // Selected count clock pulse.
    logic run; // Counting is allowed now.
    logic inc; // Count advances this cycle.
    logic wrap; // Count wraps this cycle.
    logic count_pin; // Pin feeding the synchroniser.
    logic [7:0] wbyte; // Write data lane zero.

    edge_if pins_if ();

    assign counter_on = ctrl_reg[ON_BIT];
    assign clock_source_select = ctrl_reg[CS_BIT];
    assign sync_bypass = ctrl_reg[SYNC_BIT];
    assign lowpower_osc_enable = ctrl_reg[OSC_BIT];
    assign gate_enable = ctrl_reg[GE_BIT];
    assign prescale_select = ctrl_reg[PS_HI_BIT:PS_LO_BIT];
    assign rollover_flag = irqc_reg[FLAG_BIT];
    assign wbyte = avs_writedata_in[7:0];

    // ****************************************
    // Pin conditioning.
    // ****************************************

    // The crystal pin stands in for the count pin only while the
    // internal oscillator runs; otherwise the enable is ignored.
    // The mux may glitch on a switch, but the filter absorbs it.
    assign count_pin = osc_reg ? crystal_output_pin_in
                               : external_count_clock_in;

    pin_edge_unit edge_unit (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .count_pin_in(count_pin),
        .gate_pin_n_in(gate_input_n_in),
        .port_if(pins_if.unit)
    );

    // Stopping the timer or leaving counter mode forgets the edge.
    assign pins_if.arm_clear = ~counter_on | ~clock_source_select;

    // ****************************************
    // Avalon-MM slave.
    // ****************************************

    // Each request waits one cycle, then is answered. Unmapped
    // addresses read zero and swallow writes, but still answer.
    always_comb begin
        bus_next = bus_reg;
        rdata_next = rdata_reg;
        case (bus_reg)
            BUS_IDLE: begin
                if (avs_read_in || avs_write_in) begin
                    bus_next = BUS_ANSWER;
                end
                if (avs_read_in) begin
                    // Snapshot of one byte; whole design is on one
                    // clock, so the byte never tears.
                    case (avs_address_in)
                        LOW_OFFSET: rdata_next = {24'h0, count_reg[7:0]};
                        HIGH_OFFSET: rdata_next = {24'h0, count_reg[15:8]};
                        IRQ_OFFSET: rdata_next = {28'h0, irqc_reg};
                        CTRL_OFFSET: rdata_next = {24'h0, ctrl_reg};
                        default: rdata_next = 32'h0;
                    endcase
                end
            end
            BUS_ANSWER: begin
                bus_next = BUS_IDLE;
            end
            default: begin
                bus_next = BUS_IDLE;
            end
        endcase
    end

    assign accept = (bus_reg == BUS_ANSWER);
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~accept;
    assign avs_readdata_out = rdata_reg;

    // Writes land on the answering edge, lane zero only.
    always_comb begin
        wr_low = 1'b0;
        wr_high = 1'b0;
        wr_ctrl = 1'b0;
        wr_irq = 1'b0;
        if (accept && avs_write_in && avs_byteenable_in[0]) begin
            wr_low = (avs_address_in == LOW_OFFSET);
            wr_high = (avs_address_in == HIGH_OFFSET);
            wr_ctrl = (avs_address_in == CTRL_OFFSET);
            wr_irq = (avs_address_in == IRQ_OFFSET);
        end
    end

    assign count_write = wr_low | wr_high;

    // ****************************************
    // Count path.
    // ****************************************

    // Divider gives the instruction cycle from the core clock.
    assign quarter_tick = (div_reg == QUARTER_LAST);
    assign src_pulse = clock_source_select ? pins_if.rise_pulse
                                           : quarter_tick;

    // Asleep, only the unsynchronised counter keeps going. The pin
    // is still sampled here; that is why bypass changes little else.
    always_comb begin
        run = counter_on;
        if (gate_enable && !pins_if.gate_low) begin
            run = 1'b0;
        end
        if (sleep_in && !(clock_source_select && sync_bypass)) begin
            run = 1'b0;
        end
    end

    // Prescaler and divider; a count write restarts the prescaler.
    always_comb begin
        div_next = 2'(div_reg + 2'h1);
        presc_next = presc_reg;
        inc = 1'b0;
        if (count_write) begin
            presc_next = 3'h0;
        end else if (run && src_pulse) begin
            if (presc_reg >= presc_limit(prescale_select)) begin
                presc_next = 3'h0;
                inc = 1'b1;
            end else begin
                presc_next = 3'(presc_reg + 3'h1);
            end
        end
    end

    // A write wins over the increment in the same cycle.
    always_comb begin
        count_next = count_reg;
        wrap = 1'b0;
        if (count_write) begin
            if (wr_low) begin
                count_next[7:0] = wbyte;
            end
            if (wr_high) begin
                count_next[15:8] = wbyte;
            end
        end else if (inc) begin
            wrap = (count_reg == COUNT_MAX);
            count_next = 16'(count_reg + 16'h0001);
        end
    end

    // ****************************************
    // Control, flag and outputs.
    // ****************************************

    // Writing zero to the flag clears it; a wrap in that same cycle
    // still sets it, so no event is lost.
    always_comb begin
        ctrl_next = ctrl_reg;
        irqc_next = irqc_reg;
        if (wr_ctrl) begin
            ctrl_next = wbyte & CTRL_MASK;
        end
        if (wr_irq) begin
            irqc_next[GIE_BIT:TIE_BIT] = wbyte[GIE_BIT:TIE_BIT];
            if (!wbyte[FLAG_BIT]) begin
                irqc_next[FLAG_BIT] = 1'b0;
            end
        end
        if (wrap) begin
            irqc_next[FLAG_BIT] = 1'b1;
        end
        // The wake path ignores the global enable.
        wake_next = rollover_flag & irqc_reg[TIE_BIT] & irqc_reg[PERIPHERAL_IRQ_ENABLE_BIT];
        irq_next = wake_next & irqc_reg[GIE_BIT];
        osc_next = lowpower_osc_enable & internal_oscillator_in;
    end

    // Registers only.
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            bus_reg <= BUS_IDLE;
            rdata_reg <= 32'h0;
            ctrl_reg <= CTRL_RESET;
            irqc_reg <= IRQ_RESET;
            count_reg <= COUNT_RESET;
            presc_reg <= 3'h0;
            div_reg <= 2'h0;
            irq_reg <= 1'b0;
            wake_reg <= 1'b0;
            osc_reg <= 1'b0;
        end else begin
            bus_reg <= bus_next;
            rdata_reg <= rdata_next;
            ctrl_reg <= ctrl_next;
            irqc_reg <= irqc_next;
            count_reg <= count_next;
            presc_reg <= presc_next;
            div_reg <= div_next;
            irq_reg <= irq_next;
            wake_reg <= wake_next;
            osc_reg <= osc_next;
        end
    end

    assign irq_out = irq_reg;
    assign wake_out = wake_reg;
    assign lowpower_osc_run_out = osc_reg;

    // ****************************************
    // Assertions.
    // ****************************************
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rstn_in);

    sequence wrap_s;
        inc && count_reg == COUNT_MAX && !count_write;
    endsequence

    sequence flag_up_s;
        rollover_flag && count_reg == COUNT_RESET;
    endsequence

    wrap_sets_flag_a: assert property (wrap_s |=> flag_up_s)
        else $error("wrap did not clear count and set flag");

    timer_rate_a: assert property (
        quarter_tick && run && !clock_source_select
        && prescale_select == 2'h0 && !count_write
        |=> count_reg == 16'($past(count_reg) + 16'h0001))
        else $error("timer mode missed an instruction cycle");

    source_select_a: assert property (
        !clock_source_select && !quarter_tick |-> !inc)
        else $error("timer mode counted off the instruction tick");

    pin_edge_a: assert property (
        clock_source_select && pins_if.rise_pulse && run
        && prescale_select == 2'h0 && !count_write
        |=> count_reg == 16'($past(count_reg) + 16'h0001))
        else $error("counter mode missed a rising edge");

    sleep_stop_a: assert property (
        sleep_in && !(clock_source_select && sync_bypass) |-> !inc)
        else $error("count advanced asleep outside async mode");

    gate_block_a: assert property (
        gate_enable && !pins_if.gate_low |-> !inc)
        else $error("count advanced with gate pin high");

    off_stop_a: assert property (!counter_on |-> !inc)
        else $error("count advanced while off");

    presc_limit_a: assert property (
        inc |-> presc_reg >= presc_limit(prescale_select))
        else $error("prescaler released at wrong count");

    presc_clear_a: assert property (count_write |=> presc_reg == 3'h0)
        else $error("count write did not clear prescaler");

    osc_run_a: assert property (
        ##1 osc_reg == $past(lowpower_osc_enable && internal_oscillator_in))
        else $error("crystal run output wrong");

    irq_gate_a: assert property (
        irq_out |-> $past(rollover_flag && irqc_reg[GIE_BIT]
                          && irqc_reg[TIE_BIT] && irqc_reg[PERIPHERAL_IRQ_ENABLE_BIT]))
        else $error("interrupt without all enables");

    sleep_wake_a: assert property (
        rollover_flag && irqc_reg[TIE_BIT] && irqc_reg[PERIPHERAL_IRQ_ENABLE_BIT]
        ##1 rollover_flag |-> wake_out)
        else $error("rollover did not raise wake");

    flag_hold_a: assert property (rollover_flag && !wr_irq |=> rollover_flag)
        else $error("flag dropped without software clear");

    ctrl_top_a: assert property (ctrl_reg[7] == 1'b0)
        else $error("control bit seven set");

    low_load_a: assert property (
        wr_low |=> count_reg[7:0] == $past(wbyte))
        else $error("low byte write not loaded");

    read_byte_a: assert property (
        bus_reg == BUS_IDLE && avs_read_in && avs_address_in == LOW_OFFSET
        |=> avs_readdata_out == {24'h0, $past(count_reg[7:0])})
        else $error("low byte read inconsistent");

endmodule
`default_nettype wire

// *** rtl/gated_timer_pkg.sv ***
// Shared constants, types and helpers for the gated sixteen bit timer.
package gated_timer_pkg;

    // ****************************************
    // Register byte addresses on the bus.
    // ****************************************
    localparam logic [4:0] LOW_OFFSET = 5'h04;
    localparam logic [4:0] HIGH_OFFSET = 5'h08;
    localparam logic [4:0] IRQ_OFFSET = 5'h0C;
    localparam logic [4:0] CTRL_OFFSET = 5'h10;

    // ****************************************
    // Field positions and reset values.
    // ****************************************
    localparam int ON_BIT = 0;
    localparam int CS_BIT = 1;
    localparam int SYNC_BIT = 2;
    localparam int OSC_BIT = 3;
    localparam int PS_LO_BIT = 4;
    localparam int PS_HI_BIT = 5;
    localparam int GE_BIT = 6;
    localparam int FLAG_BIT = 0;
    localparam int TIE_BIT = 1;
    localparam int PERIPHERAL_IRQ_ENABLE_BIT = 2;
    localparam int GIE_BIT = 3;
    localparam logic [7:0] CTRL_MASK = 8'h7F;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;

    // ****************************************
    // Timing: instruction cycle is four clocks.
    // ****************************************
    localparam int QUARTER_CYCLES = 4;
    localparam logic [1:0] QUARTER_LAST = 2'(QUARTER_CYCLES - 1);

    // Bus answer state: request seen, then answered.
    typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;

    // Last prescaler count before a count pulse passes.
    function automatic logic [2:0] presc_limit(input logic [1:0] sel);
        presc_limit = 3'((4'h1 << sel) - 4'h1);
    endfunction

endpackage

// *** rtl/pin_edge_unit.sv ***
// Synchroniser and edge detector for the count clock and gate pins.
`timescale 1ns/100ps
`default_nettype none
module pin_edge_unit
    import gated_timer_pkg::*;
(
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic count_pin_in,
    input wire logic gate_pin_n_in,
    edge_if.unit port_if
);

    // ****************************************
    // State.
    // ****************************************
    logic [2:0] clk_sync_reg, clk_sync_next; // Three-stage chain.
    logic [2:0] gate_sync_reg, gate_sync_next; // Three-stage chain.
    logic clk_level_reg, clk_level_next; // Filtered clock level.
    logic gate_level_reg, gate_level_next; // Filtered gate level.
    logic armed_reg, armed_next; // A falling edge was seen.
    logic rise_reg, rise_next; // Counted rising edge.

    // A level is accepted only once stages two and three agree.
    always_comb begin
        clk_sync_next = {clk_sync_reg[1:0], count_pin_in};
        gate_sync_next = {gate_sync_reg[1:0], gate_pin_n_in};
        clk_level_next = clk_level_reg;
        gate_level_next = gate_level_reg;
        if (clk_sync_reg[1] == clk_sync_reg[2]) begin
            clk_level_next = clk_sync_reg[2];
        end
        if (gate_sync_reg[1] == gate_sync_reg[2]) begin
            gate_level_next = gate_sync_reg[2];
        end
        // A rise counts only after a falling edge armed us.
        rise_next = ~clk_level_reg & clk_level_next & armed_reg;
        armed_next = armed_reg | (clk_level_reg & ~clk_level_next);
        if (port_if.arm_clear) begin
            armed_next = 1'b0;
            rise_next = 1'b0;
        end
    end

    // Registers only; the gate idles high so gated counting is held off.
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            clk_sync_reg <= 3'h0;
            gate_sync_reg <= 3'h7;
            clk_level_reg <= 1'b0;
            gate_level_reg <= 1'b1;
            armed_reg <= 1'b0;
            rise_reg <= 1'b0;
        end else begin
            clk_sync_reg <= clk_sync_next;
            gate_sync_reg <= gate_sync_next;
            clk_level_reg <= clk_level_next;
            gate_level_reg <= gate_level_next;
            armed_reg <= armed_next;
            rise_reg <= rise_next;
        end
    end

    assign port_if.rise_pulse = rise_reg;
    assign port_if.gate_low = ~gate_level_reg;

    // A counted rise always follows an armed state.
    arm_before_rise_a: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        rise_reg |-> $past(armed_reg))
        else $error("rise counted without prior falling edge");

endmodule
`default_nettype wire

// *** tb/ext_source_model.sv ***
// Behavioural model of the count clock and crystal pins.
`timescale 1ns/100ps
`default_nettype none
module ext_source_model (
    input wire logic clock_in,
    output logic count_pin_out,
    output logic crystal_pin_out
);
    // Each level lasts four clocks; the pin filter needs two.
    localparam int PHASE = 4;
    // The count pin starts low, so its first rise has no prior fall.
    initial begin
        count_pin_out = 1'b0;
        crystal_pin_out = 1'b1;
    end
    // Sends n low-high cycles on one pin, fall first, then settles.
    task automatic send_edges(input int n, input logic xtal);
        for (int i = 0; i < 2 * n; i++) begin
            @(posedge clock_in);
            if (xtal) begin
                crystal_pin_out <= i[0];
            end else begin
                count_pin_out <= i[0];
            end
            repeat (PHASE - 1) @(posedge clock_in);
        end
        repeat (8) @(posedge clock_in);
    endtask
endmodule
`default_nettype wire

// *** tb/test_gated_sixteen_bit_timer.sv ***
// Self-checking testbench for the gated sixteen bit timer.
`timescale 1ns/100ps
`default_nettype none
module test_gated_sixteen_bit_timer
    import gated_timer_pkg::*;
;
    // A read note: expected byte and allowed slack in counts.
    typedef struct {logic [7:0] exp; int tol;} note_t;
    note_t notes[$];
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [4:0] addr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] rdata;
    logic waitreq, pin, xtal, irq, wake, osc_run;
    logic gate_n = 1'b1;
    logic int_osc = 1'b0;
    logic sleep = 1'b0;
    logic [15:0] v;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    gated_sixteen_bit_timer uut (.clock_in(clock_in), .rstn_in(rstn_in),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
        .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
        .external_count_clock_in(pin), .crystal_output_pin_in(xtal),
        .gate_input_n_in(gate_n), .internal_oscillator_in(int_osc),
        .sleep_in(sleep), .irq_out(irq), .wake_out(wake),
        .lowpower_osc_run_out(osc_run));
    ext_source_model src (.clock_in(clock_in), .count_pin_out(pin),
        .crystal_pin_out(xtal));

    always #20 clock_in = ~clock_in;

    // The ceiling is several times the expected run, so a hang ends here.
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Slack covers the unknown phase of the instruction tick.
    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input int tol);
        comparisons++;
        if ((^got === 1'bx) || int'(got) > int'(exp) + tol ||
            int'(got) + tol < int'(exp)) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Read data is taken at the edge where waitrequest is low.
    always @(posedge clock_in) begin
        if (rd && waitreq === 1'b0) begin
            if (notes.size() == 0) begin
                num_errors++;
                $display("mismatch at %0t: read without a note", $time);
            end else begin
                check(rdata[7:0], notes[0].exp, notes[0].tol);
                void'(notes.pop_front());
            end
        end
    end

    // ****************************************
    // Bus cycles: the request holds until waitrequest is seen low.
    // ****************************************
    task automatic bus_op(input logic [4:0] a, input logic [7:0] d,
                          input logic is_rd);
        @(posedge clock_in);
        addr <= a;
        wdata <= {24'h000000, d};
        rd <= is_rd;
        wr <= !is_rd;
        do @(posedge clock_in); while (waitreq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic bus_write(input logic [4:0] a, input logic [7:0] d);
        bus_op(a, d, 1'b0);
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] e,
                          input int tol);
        notes.push_back('{e, tol});
        bus_op(a, 8'h00, 1'b1);
    endtask
    // Stops the timer before clearing the count, so no write collides.
    task automatic zero();
        bus_write(CTRL_OFFSET, 8'h00);
        bus_write(LOW_OFFSET, 8'h00);
        bus_write(HIGH_OFFSET, 8'h00);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    initial begin
        v = 16'($urandom(22289));
        repeat (8) @(posedge clock_in);
        rstn_in <= 1'b1;
        rd_chk(CTRL_OFFSET, CTRL_RESET, 0);
        rd_chk(IRQ_OFFSET, 8'h00, 0);
        rd_chk(LOW_OFFSET, 8'h00, 0);
        bus_write(CTRL_OFFSET, 8'hFF);
        rd_chk(CTRL_OFFSET, CTRL_MASK, 0);
        rd_chk(5'h14, 8'h00, 0);
        done("registers");
        // The first rise after reset lacks a fall and is not counted.
        zero();
        bus_write(CTRL_OFFSET, 8'h03);
        src.send_edges(4, 1'b0);
        rd_chk(LOW_OFFSET, 8'h03, 0);
        for (int ps = 0; ps < 4; ps++) begin
            zero();
            bus_write(CTRL_OFFSET, 8'(8'h03 | (ps << 4)));
            src.send_edges(8, 1'b0);
            rd_chk(LOW_OFFSET, 8'(8 >> ps), 0);
        end
        // A count write must drop the seven pulses already divided.
        zero();
        bus_write(CTRL_OFFSET, 8'h33);
        src.send_edges(7, 1'b0);
        bus_write(LOW_OFFSET, 8'h00);
        src.send_edges(4, 1'b0);
        rd_chk(LOW_OFFSET, 8'h00, 0);
        src.send_edges(4, 1'b0);
        rd_chk(LOW_OFFSET, 8'h01, 0);
        zero();
        bus_write(CTRL_OFFSET, 8'h02);
        src.send_edges(2, 1'b0);
        rd_chk(LOW_OFFSET, 8'h00, 0);
        done("counter");
        // The sync bit must not matter with the internal source.
        for (int k = 0; k < 2; k++) begin
            zero();
            bus_write(CTRL_OFFSET, k ? 8'h05 : 8'h01);
            repeat (400) @(posedge clock_in);
            bus_write(CTRL_OFFSET, 8'h00);
            rd_chk(LOW_OFFSET, 8'h64, 2);
        end
        zero();
        bus_write(CTRL_OFFSET, 8'h41);
        repeat (200) @(posedge clock_in);
        rd_chk(LOW_OFFSET, 8'h00, 0);
        bus_write(CTRL_OFFSET, 8'h43);
        src.send_edges(2, 1'b0);
        rd_chk(LOW_OFFSET, 8'h00, 0);
        gate_n <= 1'b0;
        src.send_edges(2, 1'b0);
        rd_chk(LOW_OFFSET, 8'h02, 0);
        gate_n <= 1'b1;
        bus_write(CTRL_OFFSET, 8'h03);
        src.send_edges(2, 1'b0);
        rd_chk(LOW_OFFSET, 8'h04, 0);
        done("gate");
        zero();
        sleep <= 1'b1;
        bus_write(CTRL_OFFSET, 8'h05);
        repeat (200) @(posedge clock_in);
        rd_chk(LOW_OFFSET, 8'h00, 0);
        bus_write(CTRL_OFFSET, 8'h03);
        src.send_edges(2, 1'b0);
        rd_chk(LOW_OFFSET, 8'h00, 0);
        bus_write(CTRL_OFFSET, 8'h07);
        src.send_edges(2, 1'b0);
        rd_chk(LOW_OFFSET, 8'h02, 0);
        sleep <= 1'b0;
        zero();
        int_osc <= 1'b1;
        bus_write(CTRL_OFFSET, 8'h0B);
        repeat (3) @(posedge clock_in);
        check(8'(osc_run), 8'h01, 0);
        src.send_edges(2, 1'b1);
        rd_chk(LOW_OFFSET, 8'h02, 0);
        int_osc <= 1'b0;
        repeat (3) @(posedge clock_in);
        check(8'(osc_run), 8'h00, 0);
        done("sleep and oscillator");
        // Wrap from all ones; the flag holds until written with zero.
        zero();
        bus_write(IRQ_OFFSET, 8'h0E);
        bus_write(LOW_OFFSET, 8'hFE);
        bus_write(HIGH_OFFSET, 8'hFF);
        bus_write(CTRL_OFFSET, 8'h01);
        repeat (20) @(posedge clock_in);
        check(8'(irq), 8'h01, 0);
        rd_chk(IRQ_OFFSET, 8'h0F, 0);
        rd_chk(HIGH_OFFSET, 8'h00, 0);
        bus_write(IRQ_OFFSET, 8'h07);
        repeat (3) @(posedge clock_in);
        check(8'(irq), 8'h00, 0);
        check(8'(wake), 8'h01, 0);
        rd_chk(IRQ_OFFSET, 8'h07, 0);
        bus_write(IRQ_OFFSET, 8'h06);
        rd_chk(IRQ_OFFSET, 8'h06, 0);
        check(8'(wake), 8'h00, 0);
        done("rollover");
        // Four writes three clocks apart meet every tick phase once.
        bus_write(CTRL_OFFSET, 8'h01);
        repeat (4) bus_write(LOW_OFFSET, 8'h5A);
        bus_write(CTRL_OFFSET, 8'h00);
        rd_chk(LOW_OFFSET, 8'h5A, 1);
        zero();
        for (int k = 0; k < 4; k++) begin
            v = 16'($urandom());
            bus_write(LOW_OFFSET, v[7:0]);
            bus_write(HIGH_OFFSET, v[15:8]);
            rd_chk(LOW_OFFSET, v[7:0], 0);
            rd_chk(HIGH_OFFSET, v[15:8], 0);
        end
        done("load");
        end_of_test();
    end
endmodule
`default_nettype wire
